// [rtl/dcad_pkg.sv]
package dcad_pkg;
  // Command code {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_ZQC = 4'h6;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int ADDR_W = 15;
  localparam int BANK_W = 3;
  localparam int DQ_W = 8;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int TDQS_BIT = 11;
  // Rtt_Nom field bits in MR1, Rtt_WR field in MR2
  localparam int RTT_NOM_B0 = 2;
  localparam int RTT_NOM_B1 = 6;
  localparam int RTT_NOM_B2 = 9;
  localparam int RTT_WR_LO = 9;
  localparam int RTT_WR_HI = 10;
  localparam logic [BANK_W-1:0] MR1_SEL = 3'h1;
  localparam logic [BANK_W-1:0] MR2_SEL = 3'h2;
  localparam logic [ADDR_W-1:0] MR_RST = 15'h0000;
  typedef enum logic [3:0] {
    DCAD_NOP, DCAD_DESEL, DCAD_MRS, DCAD_REF, DCAD_PRE, DCAD_PREA,
    DCAD_ACT, DCAD_WR, DCAD_RD, DCAD_ZQC
  } dcad_cmd_t;
endpackage

// [rtl/dcad_edge.sv]
`timescale 1ns/1ps
// Two-flop synchroniser plus rising and falling edge detect
module dcad_edge (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule

// [rtl/dcad_decode.sv]
`timescale 1ns/1ps
// Summary of operation
// - Commands are ignored whenever chip select is sampled high.
// - Chip select forms one bit of the command code.
// - Row, column strobe and write enable select the command, qualified by chip select.
// - Write beats with mask sampled high are not stored while MR1 A11 is clear.
// - Mask sampled on both strobe edges, one bit per beat.
// - MR1 bit A11 picks data mask or termination strobe function.
// - A11 set gives strobe termination on TDQS pair; clear gives mask.
// - Bank address picks the bank of activate, read, write, precharge.
// - Bank address picks the mode register during mode register set.
// - A10 on read or write requests auto precharge.
// - Precharge hits named bank with A10 low, all banks with A10 high.
// - A0 to A14 give row on activate, column on read or write.
// - Address inputs give the op-code during mode register set.
// - A12 high means full burst, low means chopped burst.
// - Termination turns on when its control input registers high.
// - Termination covers data, strobes, mask, and complement TDQS when enabled.
// - Termination input ignored when MR1 and MR2 both disable it.
module dcad_decode #(
  parameter int ADDR_W = dcad_pkg::ADDR_W,
  parameter int BANK_W = dcad_pkg::BANK_W,
  parameter int DQ_W = dcad_pkg::DQ_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic odt,
  input wire logic dqs,
  input wire logic dm,
  input wire logic [DQ_W-1:0] dq,
  input wire logic wr_burst,
  output dcad_pkg::dcad_cmd_t cmd,
  output logic cmd_valid,
  output logic [BANK_W-1:0] cmd_bank,
  output logic [ADDR_W-1:0] row_addr,
  output logic [ADDR_W-1:0] col_addr,
  output logic auto_pre,
  output logic full_burst,
  output logic pre_all,
  output logic [BANK_W-1:0] mr_sel,
  output logic [ADDR_W-1:0] mr_opcode,
  output logic mr_wr,
  output logic [ADDR_W-1:0] mr1,
  output logic [ADDR_W-1:0] mr2,
  output logic [DQ_W-1:0] wr_data,
  output logic wr_store,
  output logic wr_masked,
  output logic term_on,
  output logic term_dq,
  output logic term_dqs,
  output logic term_dm,
  output logic term_tdqs_n,
  output logic tdqs_mode
);
  logic ck_rise;
  logic ck_fall;
  logic dqs_rise;
  logic dqs_fall;
  // Pins synchronised; skew between pin synchronisers is the controller's to avoid
  logic cs1, cs2, ras1, ras2, cas1, cas2, we1, we2, odt1, odt2, dm1, dm2, wb1, wb2;
  logic [BANK_W-1:0] ba1, ba2;
  logic [ADDR_W-1:0] ad1, ad2;
  logic [DQ_W-1:0] dq1, dq2;
  logic [3:0] code;
  dcad_pkg::dcad_cmd_t next_cmd;
  logic rtt_nom_off;
  logic rtt_wr_off;

  dcad_edge u_ck (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(ck),
    .rise(ck_rise),
    .fall(ck_fall)
  );

  dcad_edge u_dqs (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din(dqs),
    .rise(dqs_rise),
    .fall(dqs_fall)
  );

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      {cs1, cs2} <= 2'h3;
      {ras1, ras2, cas1, cas2, we1, we2} <= 6'h3F;
      {odt1, odt2, dm1, dm2, wb1, wb2} <= 6'h00;
      ba1 <= '0;
      ba2 <= '0;
      ad1 <= '0;
      ad2 <= '0;
      dq1 <= '0;
      dq2 <= '0;
    end else begin
      cs1 <= cs_n;
      cs2 <= cs1;
      ras1 <= ras_n;
      ras2 <= ras1;
      cas1 <= cas_n;
      cas2 <= cas1;
      we1 <= we_n;
      we2 <= we1;
      odt1 <= odt;
      odt2 <= odt1;
      dm1 <= dm;
      dm2 <= dm1;
      wb1 <= wr_burst;
      wb2 <= wb1;
      ba1 <= bank_addr;
      ba2 <= ba1;
      ad1 <= addr;
      ad2 <= ad1;
      dq1 <= dq;
      dq2 <= dq1;
    end
  end

  // Chip select is the top code bit, so any high select decodes as deselect
  assign code = {cs2, ras2, cas2, we2};

  always_comb begin
    if (code[3]) begin
      next_cmd = dcad_pkg::DCAD_DESEL;
    end else begin
      unique case (code)
        dcad_pkg::CMD_MRS: next_cmd = dcad_pkg::DCAD_MRS;
        dcad_pkg::CMD_REF: next_cmd = dcad_pkg::DCAD_REF;
        dcad_pkg::CMD_PRE: next_cmd = ad2[dcad_pkg::AP_BIT] ? dcad_pkg::DCAD_PREA : dcad_pkg::DCAD_PRE;
        dcad_pkg::CMD_ACT: next_cmd = dcad_pkg::DCAD_ACT;
        dcad_pkg::CMD_WR: next_cmd = dcad_pkg::DCAD_WR;
        dcad_pkg::CMD_RD: next_cmd = dcad_pkg::DCAD_RD;
        dcad_pkg::CMD_ZQC: next_cmd = dcad_pkg::DCAD_ZQC;
        default: next_cmd = dcad_pkg::DCAD_NOP;
      endcase
    end
  end

  // Command and address captured only on the true clock rising edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cmd <= dcad_pkg::DCAD_NOP;
      cmd_valid <= 1'b0;
      cmd_bank <= '0;
      row_addr <= '0;
      col_addr <= '0;
      auto_pre <= 1'b0;
      full_burst <= 1'b1;
      pre_all <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (ck_rise) begin
        cmd <= next_cmd;
        cmd_valid <= ~code[3];
        if (!code[3]) begin
          cmd_bank <= ba2;
          if (next_cmd == dcad_pkg::DCAD_ACT) begin
            row_addr <= ad2;
          end
          if (next_cmd == dcad_pkg::DCAD_RD || next_cmd == dcad_pkg::DCAD_WR) begin
            col_addr <= ad2;
            auto_pre <= ad2[dcad_pkg::AP_BIT];
            full_burst <= ad2[dcad_pkg::BC_BIT];
          end
          if (next_cmd == dcad_pkg::DCAD_PRE || next_cmd == dcad_pkg::DCAD_PREA) begin
            pre_all <= ad2[dcad_pkg::AP_BIT];
          end
        end
      end
    end
  end

  // Mode register load
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mr_sel <= '0;
      mr_opcode <= '0;
      mr_wr <= 1'b0;
      mr1 <= dcad_pkg::MR_RST;
      mr2 <= dcad_pkg::MR_RST;
    end else begin
      mr_wr <= 1'b0;
      if (ck_rise && next_cmd == dcad_pkg::DCAD_MRS) begin
        mr_sel <= ba2;
        mr_opcode <= ad2;
        mr_wr <= 1'b1;
        if (ba2 == dcad_pkg::MR1_SEL) begin
          mr1 <= ad2;
        end
        if (ba2 == dcad_pkg::MR2_SEL) begin
          mr2 <= ad2;
        end
      end
    end
  end

  assign rtt_nom_off = ~(mr1[dcad_pkg::RTT_NOM_B0] | mr1[dcad_pkg::RTT_NOM_B1] | mr1[dcad_pkg::RTT_NOM_B2]);
  assign rtt_wr_off = ~(mr2[dcad_pkg::RTT_WR_LO] | mr2[dcad_pkg::RTT_WR_HI]);

  // Termination enable, registered at the clock rise
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      term_on <= 1'b0;
      term_dq <= 1'b0;
      term_dqs <= 1'b0;
      term_dm <= 1'b0;
      term_tdqs_n <= 1'b0;
      tdqs_mode <= 1'b0;
    end else begin
      tdqs_mode <= mr1[dcad_pkg::TDQS_BIT];
      if (rtt_nom_off && rtt_wr_off) begin
        term_on <= 1'b0;
        term_dq <= 1'b0;
        term_dqs <= 1'b0;
        term_dm <= 1'b0;
        term_tdqs_n <= 1'b0;
      end else begin
        if (ck_rise) begin
          term_on <= odt2;
          term_dq <= odt2;
          term_dqs <= odt2;
          term_dm <= odt2;
        end
        // Follows the mode bit every cycle, so a mode change never leaves a stale pin setting
        term_tdqs_n <= (ck_rise ? odt2 : term_on) & mr1[dcad_pkg::TDQS_BIT];
      end
    end
  end

  // Write beats: one mask sample per strobe edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_data <= '0;
      wr_store <= 1'b0;
      wr_masked <= 1'b0;
    end else begin
      wr_store <= 1'b0;
      wr_masked <= 1'b0;
      if (wb2 && (dqs_rise || dqs_fall)) begin
        wr_data <= dq2;
        // In termination strobe mode the pin is no mask, so every beat is kept
        if (dm2 && !mr1[dcad_pkg::TDQS_BIT]) begin
          wr_masked <= 1'b1;
        end else begin
          wr_store <= 1'b1;
        end
      end
    end
  end
endmodule

// [bench/dcad_decode_checker.sv]
`timescale 1ns/1ps
module dcad_decode_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire dcad_pkg::dcad_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic mr_wr,
  input wire logic [14:0] mr1,
  input wire logic [14:0] mr2,
  input wire logic wr_store,
  input wire logic wr_masked,
  input wire logic term_on,
  input wire logic term_dq,
  input wire logic term_tdqs_n,
  input wire logic tdqs_mode
);
  // Both Rtt fields off
  wire off = !(mr1[2] | mr1[6] | mr1[9] | mr2[9] | mr2[10]);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_desel_quiet: assert property (cmd == dcad_pkg::DCAD_DESEL |-> !cmd_valid)
    else $error("valid on deselect");
  a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("valid too long");
  a_mrs_write: assert property (mr_wr == (cmd_valid && cmd == dcad_pkg::DCAD_MRS))
    else $error("mode write mismatch");
  a_mr_only_mrs: assert property ($changed(mr1) || $changed(mr2) |-> mr_wr)
    else $error("mode reg changed");
  a_term_dq: assert property (term_dq == term_on)
    else $error("dq term mismatch");
  a_tdqs_term: assert property (term_tdqs_n == (term_on && tdqs_mode))
    else $error("tdqs term mismatch");
  a_rtt_off: assert property (off [*2] |-> !term_on)
    else $error("term while off");
  a_mask_mode: assert property (wr_masked |-> !wr_store && !tdqs_mode)
    else $error("bad mask");
  c_mrs: cover property (mr_wr);
  c_mask: cover property (wr_masked);
  c_tdqs: cover property (term_tdqs_n);
endmodule
bind dcad_decode dcad_decode_checker chk_i (.clk_sys, .nrst, .cmd, .cmd_valid, .mr_wr, .mr1, .mr2,
  .wr_store, .wr_masked, .term_on, .term_dq, .term_tdqs_n, .tdqs_mode);

// [bench/dcad_ctrl_model.sv]
`timescale 1ns/1ps
module dcad_ctrl_model (
  input wire logic clk_sys,
  output logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] bank_addr,
  output logic [14:0] addr,
  output logic odt,
  output logic dqs,
  output logic dm,
  output logic [7:0] dq,
  output logic wr_burst
);
  initial begin
    {ck, cs_n, ras_n, cas_n, we_n, odt, dqs, dm, wr_burst} = 9'h0f0;
    {bank_addr, addr, dq} = 26'h000_0000;
  end
  // Four cycles of setup cover the pin synchronisers
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a, input logic o);
    @(negedge clk_sys);
    {cs_n, ras_n, cas_n, we_n, bank_addr, addr, odt} = {c, b, a, o};
    repeat (4) @(negedge clk_sys);
    ck = 1'b1;
    repeat (4) @(negedge clk_sys);
    {ck, cs_n, bank_addr, addr} = {2'b01, ~b, ~a};
  endtask
  task automatic beat(input logic w, input logic [7:0] d, input logic m);
    @(negedge clk_sys);
    {wr_burst, dq, dm, dqs} = {w, d, m, ~dqs ^ !w};
    repeat (4) @(negedge clk_sys);
    dq = ~d;
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ck, cs_n, ras_n, cas_n, we_n, odt, dqs, dm, wr_burst, cmd_valid, auto_pre, full_burst, pre_all, mr_wr;
  logic wr_store, wr_masked, term_on, term_dq, term_dqs, term_dm, term_tdqs_n, tdqs_mode, en;
  logic [2:0] bank_addr, cmd_bank, mr_sel;
  logic [14:0] addr, row_addr, col_addr, mr_opcode, mr1, mr2, m1, m2;
  logic [7:0] dq, wr_data;
  logic [21:0] e;
  logic [8:0] f;
  logic [21:0] cq[$];
  logic [8:0] bq[$];
  int compares = 0;
  int miscompares = 0;
  dcad_pkg::dcad_cmd_t cmd, x;
  dcad_pkg::dcad_cmd_t tab[8] = '{dcad_pkg::DCAD_MRS, dcad_pkg::DCAD_REF, dcad_pkg::DCAD_PRE, dcad_pkg::DCAD_ACT,
    dcad_pkg::DCAD_WR, dcad_pkg::DCAD_RD, dcad_pkg::DCAD_ZQC, dcad_pkg::DCAD_NOP};
  always #5 clk_sys = ~clk_sys;
  dcad_ctrl_model mdl (.*);
  dcad_decode dut (.*);
  task automatic chk(string n, logic [15:0] ex, logic [15:0] g);
    compares++;
    if (g !== ex) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, ex, g);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cm(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a, input logic o);
    if (!c[3]) cq.push_back({c, b, a});
    if (c == 4'h0 && b == 3'h1) m1 = a;
    if (c == 4'h0 && b == 3'h2) m2 = a;
    mdl.issue(c, b, a, o);
    en = o & (m1[2] | m1[6] | m1[9] | m2[9] | m2[10]);
    if (c[3]) chk("cmd_desel", dcad_pkg::DCAD_DESEL, cmd);
    chk("term_on", en, term_on);
    chk("term_dq", en, term_dq);
    chk("term_dqs", en, term_dqs);
    chk("term_dm", en, term_dm);
    chk("term_tdqs_n", en & m1[11], term_tdqs_n);
    chk("mr1", m1, mr1);
    chk("mr2", m2, mr2);
    chk("tdqs_mode", m1[11], tdqs_mode);
  endtask
  task automatic bt(input logic [7:0] d, input logic m);
    bq.push_back({!(m & !m1[11]), d});
    mdl.beat(1'b1, d, m);
  endtask
  // Results show mid-cycle, so sample at the falling edge
  always @(negedge clk_sys) begin
    if (cmd_valid === 1'b1) begin
      e = cq.pop_front();
      x = (e[21:18] == 4'h2 && e[10]) ? dcad_pkg::DCAD_PREA : tab[e[20:18]];
      chk("cmd", x, cmd);
      chk("mr_wr", e[21:18] == 4'h0, mr_wr);
      if (e[21:18] inside {2, 3, 4, 5}) chk("cmd_bank", e[17:15], cmd_bank);
      if (e[21:18] == 4'h3) chk("row_addr", e[14:0], row_addr);
      if (e[21:18] inside {4, 5}) chk("col_addr", e[14:0], col_addr);
      if (e[21:18] inside {4, 5}) chk("auto_pre", e[10], auto_pre);
      if (e[21:18] inside {4, 5}) chk("full_burst", e[12], full_burst);
      if (e[21:18] == 4'h2) chk("pre_all", e[10], pre_all);
      if (e[21:18] == 4'h0) chk("mr_sel", e[17:15], mr_sel);
      if (e[21:18] == 4'h0) chk("mr_opcode", e[14:0], mr_opcode);
    end
    if (wr_store === 1'b1 || wr_masked === 1'b1) begin
      f = bq.pop_front();
      chk("wr_store", f[8], wr_store);
      chk("wr_masked", !f[8], wr_masked);
      if (f[8]) chk("wr_data", f[7:0], wr_data);
    end
  end
  initial begin
    void'($urandom(54));
    {m1, m2} = 30'h0000_0000;
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    cm(4'h7, 3'h0, 15'h0000, 1'b1);
    cm(4'h0, 3'h1, 15'h0004, 1'b0);
    for (int i = 0; i < 14; i++) begin
      cm(4'(i % 7 + 1), 3'($urandom), 15'($urandom) & 15'h7bff | 15'(i / 7) << 10, 1'($urandom));
    end
    cm(4'h8, 3'h1, 15'h7fff, 1'b1);
    cm(4'h0, 3'h3, 15'($urandom), 1'b0);
    for (int i = 0; i < 6; i++) bt(8'($urandom), i[0]);
    mdl.beat(1'b0, 8'h00, 1'b0);
    cm(4'h0, 3'h1, 15'h0800, 1'b0);
    cm(4'h0, 3'h2, 15'h0200, 1'b0);
    cm(4'h7, 3'h0, 15'h0000, 1'b1);
    for (int i = 0; i < 3; i++) bt(8'($urandom), 1'b1);
    mdl.beat(1'b0, 8'h00, 1'b0);
    cm(4'h0, 3'h2, 15'h0000, 1'b0);
    cm(4'h7, 3'h0, 15'h0000, 1'b1);
    repeat (20) @(negedge clk_sys);
    chk("pending", 16'h0000, 16'(cq.size() + bq.size()));
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
endmodule
